// >>> ccr_defs.svh
// constants for the channel configuration register bank
// assumes command bytes arrive already deframed from the host command port
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
// command codes, upper seven bits of the command byte; the two real-time reads are whole bytes
`define CCR_CMD_SCALE_GAIN   7'h28
`define CCR_CMD_LINE_DATA    7'h29
`define CCR_CMD_LINE_DIR     7'h2A
`define CCR_CMD_OPER_FUNC    7'h30
`define CCR_CMD_IRQ_MASK     7'h36
`define CCR_CMD_CHAN_ENABLE  7'h25
`define CCR_CMD_RT_READ      8'h4D
`define CCR_CMD_RT_READ_CLR  8'h4F
// field positions
`define CCR_BIT_ATTEN_DIS    7
`define CCR_BIT_TX_GAIN      6
`define CCR_BIT_RX_LOSS      5
`define CCR_BIT_MUXED        5
`define CCR_BIT_CH_ACTIVE    6
`define CCR_BIT_CLK_FAIL     5
`define CCR_BIT_LINEAR       7
`define CCR_BIT_MULAW        6
`define CCR_BIT_OUT6         6
`define CCR_BIT_OUT7         7
// reset values
`define CCR_RST_SCALE_GAIN   8'h00
`define CCR_RST_LINE_DATA    8'h00
`define CCR_RST_LINE_DIR     5'h00
`define CCR_RST_OPER_FUNC    8'h00
`define CCR_RST_IRQ_MASK     8'hFF
`define CCR_RST_CHAN_ENABLE  4'hF
// scale code values
`define CCR_SCALE_LOOPBACK   5'h10
`define CCR_SCALE_CUTOFF     5'h00
`endif

// >>> ccr_pkg.sv
// types for the channel configuration register bank
// assumes ccr_defs.svh supplies the numeric constants
package ccr_pkg;
  typedef struct packed {
    logic       attenDisable;
    logic       txGainSel;
    logic       rxLossSel;
    logic [4:0] scaleCode;
  } ccr_scale_type;

  typedef struct packed {
    logic linearSel;
    logic muLawSel;
    logic rxGainProg;
    logic txGainProg;
    logic xProg;
    logic rProg;
    logic zProg;
    logic bProg;
  } ccr_oper_type;

  typedef struct packed {
    logic       valid;
    logic       isRead;
    logic [6:0] code;
    logic [7:0] data;
  } ccr_cmd_type;
endpackage

// >>> ccr_channel_config_registers.sv
// per-channel configuration and status registers of a four-channel codec
// assumes the command port framer delivers one command byte plus data per
// request; read data answers on the next cycle
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_channel_config_registers
  import ccr_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // host command port, deframed
  input  wire logic                 cmdValid,
  input  wire logic [7:0]           cmdByte,
  input  wire logic [7:0]           cmdData,
  output logic      [7:0]           readData,
  output logic                      readValid,
  // channel enable and selection
  input  wire logic [NUM_CH-1:0]    chanEnableWr,
  input  wire logic                 chanEnableLoad,
  output logic      [NUM_CH-1:0]    chanEnable,
  // device status
  input  wire logic [NUM_CH-1:0]    channelActive,
  input  wire logic                 clockSyncFail,
  input  wire logic                 e1MultiplexEnable,
  input  wire logic [2*NUM_CH-1:0]  realtimeBits,
  // line interface pins, bits 4:0 two-way
  input  wire logic [4:0]           lineIoIn,
  output logic      [4:0]           lineIoOut,
  output logic      [4:0]           lineIoOe,
  output logic      [NUM_CH-1:0]    muxedLineBit,
  output logic      [NUM_CH-1:0]    lineOutBit6,
  output logic      [NUM_CH-1:0]    lineOutBit7,
  // decoded controls toward the analog and filter paths
  output ccr_scale_type [NUM_CH-1:0] scaleCfg,
  output logic      [NUM_CH-1:0]    fullLoopback,
  output logic      [NUM_CH-1:0]    scaleCutoff,
  output ccr_oper_type  [NUM_CH-1:0] operCfg,
  // interrupt, active low
  output logic                      irq_n
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]        scaleReg    [NUM_CH];
  logic [7:0]        lineData    [NUM_CH];
  logic [4:0]        lineDir     [NUM_CH];
  logic [7:0]        operReg     [NUM_CH];
  logic [7:0]        irqMask;
  logic [2*NUM_CH-1:0] rtPrev;
  logic [2*NUM_CH-1:0] rtPending;
  logic [NUM_CH-1:0] chanEn;

  logic [7:0]        next_scaleReg [NUM_CH];
  logic [7:0]        next_lineData [NUM_CH];
  logic [4:0]        next_lineDir  [NUM_CH];
  logic [7:0]        next_operReg  [NUM_CH];
  logic [7:0]        next_irqMask;
  logic [2*NUM_CH-1:0] next_rtPending;
  logic [NUM_CH-1:0] next_chanEn;
  logic [7:0]        next_readData;
  logic              next_readValid;

  logic [6:0]          cmdCode;
  logic                cmdRead;
  logic                cmdWrite;
  logic                maskCmd;
  logic                rtReadCmd;
  logic                rtClearCmd;
  logic                anyChanEn;
  int                  firstCh;
  logic [2*NUM_CH-1:0] next_rtPrev;
  logic [2*NUM_CH-1:0] rtChanged;
  logic [2*NUM_CH-1:0] rtUnmaskedChange;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // command decode
  assign cmdCode    = cmdByte[7:1];
  assign cmdRead    = cmdByte[0];
  assign cmdWrite   = cmdValid && !cmdRead;
  assign maskCmd    = cmdValid && (cmdCode == `CCR_CMD_IRQ_MASK);
  assign rtReadCmd  = cmdValid && (cmdByte == `CCR_CMD_RT_READ || cmdByte == `CCR_CMD_RT_READ_CLR);
  assign rtClearCmd = cmdValid && (cmdByte == `CCR_CMD_RT_READ_CLR);
  assign anyChanEn  = |chanEn;

  // reads answer for the lowest enabled channel
  always_comb begin
    firstCh = 0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (chanEn[c]) begin
        firstCh = c;
      end
    end
  end

  // ----------------------------------------
  // channel enable
  // ----------------------------------------
  always_comb begin
    next_chanEn = chanEn;
    if (chanEnableLoad) begin
      next_chanEn = chanEnableWr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chanEn <= `CCR_RST_CHAN_ENABLE;
    end else begin
      chanEn <= next_chanEn;
    end
  end

  // ----------------------------------------
  // channel registers
  // ----------------------------------------
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      next_scaleReg[c] = scaleReg[c];
      next_lineData[c] = lineData[c];
      next_lineDir[c]  = lineDir[c];
      next_operReg[c]  = operReg[c];
      if (cmdWrite && chanEn[c]) begin
        if (cmdCode == `CCR_CMD_SCALE_GAIN) begin
          next_scaleReg[c] = cmdData;
        end else if (cmdCode == `CCR_CMD_LINE_DATA) begin
          next_lineData[c] = cmdData;
        end else if (cmdCode == `CCR_CMD_LINE_DIR) begin
          next_lineDir[c] = cmdData[4:0];
        end else if (cmdCode == `CCR_CMD_OPER_FUNC) begin
          next_operReg[c] = cmdData;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        scaleReg[c] <= `CCR_RST_SCALE_GAIN;
        lineData[c] <= `CCR_RST_LINE_DATA;
        lineDir[c]  <= `CCR_RST_LINE_DIR;
        operReg[c]  <= `CCR_RST_OPER_FUNC;
      end
    end else begin
      scaleReg <= next_scaleReg;
      lineData <= next_lineData;
      lineDir  <= next_lineDir;
      operReg  <= next_operReg;
    end
  end

  // ----------------------------------------
  // real-time interrupt
  // ----------------------------------------
  // masked changes never set pending
  assign rtChanged        = rtPrev ^ realtimeBits;
  assign rtUnmaskedChange = rtChanged & ~irqMask[2*NUM_CH-1:0];

  always_comb begin
    next_irqMask = irqMask;
    next_rtPrev  = realtimeBits;
    next_rtPending = rtPending | rtUnmaskedChange;
    if (maskCmd && !cmdRead) begin
      next_irqMask = cmdData;
    end
    // clearing read; a fresh change wins
    if (rtClearCmd) begin
      next_rtPending = rtUnmaskedChange;
    end
  end

  // edge history resets to zero; harmless while all bits reset masked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqMask   <= `CCR_RST_IRQ_MASK;
      rtPrev    <= '0;
      rtPending <= '0;
    end else begin
      irqMask   <= next_irqMask;
      rtPrev    <= next_rtPrev;
      rtPending <= next_rtPending;
    end
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_comb begin
    next_readData  = 8'h00;
    next_readValid = 1'b0;
    if (maskCmd && cmdRead) begin
      next_readData  = irqMask;
      next_readValid = 1'b1;
    end else if (rtReadCmd) begin
      next_readData  = 8'(realtimeBits);
      next_readValid = 1'b1;
    end else if (cmdValid && cmdRead && cmdCode == `CCR_CMD_LINE_DIR) begin
      next_readValid = 1'b1;
      next_readData[`CCR_BIT_CLK_FAIL] = clockSyncFail;
      if (anyChanEn) begin
        next_readData[4:0] = lineDir[firstCh];
        next_readData[`CCR_BIT_CH_ACTIVE] = channelActive[firstCh];
      end
    end else if (cmdValid && cmdRead && anyChanEn) begin
      // reads return the lowest enabled channel
      if (cmdCode == `CCR_CMD_SCALE_GAIN) begin
        next_readData  = scaleReg[firstCh];
        next_readValid = 1'b1;
      end else if (cmdCode == `CCR_CMD_LINE_DATA) begin
        next_readData  = lineData[firstCh];
        next_readValid = 1'b1;
      end else if (cmdCode == `CCR_CMD_OPER_FUNC) begin
        next_readData  = operReg[firstCh];
        next_readValid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readData  <= 8'h00;
      readValid <= 1'b0;
    end else begin
      readData  <= next_readData;
      readValid <= next_readValid;
    end
  end

  // ----------------------------------------
  // decoded outputs
  // ----------------------------------------
  // two-way pins shared: lowest channel with the pin set as output owns it, enabled or not
  always_comb begin
    lineIoOut = 5'h00;
    lineIoOe  = 5'h00;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      for (int b = 0; b < 5; b++) begin
        if (lineDir[c][b]) begin
          lineIoOut[b] = lineData[c][b < `CCR_BIT_MUXED ? b : b + 1];
          lineIoOe[b]  = 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      // muxed bit gated by E1 mode
      muxedLineBit[c] = e1MultiplexEnable & lineData[c][`CCR_BIT_MUXED];
      lineOutBit6[c]  = lineData[c][`CCR_BIT_OUT6];
      lineOutBit7[c]  = lineData[c][`CCR_BIT_OUT7];
      scaleCfg[c]     = scaleReg[c];
      fullLoopback[c] = scaleReg[c][4:0] == `CCR_SCALE_LOOPBACK;
      scaleCutoff[c]  = scaleReg[c][4:0] == `CCR_SCALE_CUTOFF;
      operCfg[c]      = operReg[c];
    end
  end

  assign chanEnable = chanEn;
  assign irq_n = ~|rtPending;

endmodule // ccr_channel_config_registers

// >>> ccr_checker.sv
// assertions for the channel configuration register bank
// assumes binding onto the top module, one clock domain
`timescale 1ns/1ps
module ccr_checker
  import ccr_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // command port and status
  input wire logic                  cmdValid,
  input wire logic [7:0]            cmdByte,
  input wire logic [7:0]            cmdData,
  input wire logic [7:0]            readData,
  input wire logic                  readValid,
  input wire logic [NUM_CH-1:0]     chanEnable,
  input wire logic                  clockSyncFail,
  // decoded outputs
  input wire ccr_scale_type [NUM_CH-1:0] scaleCfg,
  input wire logic [NUM_CH-1:0]     fullLoopback,
  input wire logic [NUM_CH-1:0]     scaleCutoff,
  input wire ccr_oper_type [NUM_CH-1:0] operCfg,
  input wire logic                  irq_n
);
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // only a clearing real-time read may release the pin
  wire clrReq = cmdValid && cmdByte == 8'h4F;
  sequence s_take(logic [7:0] b);
    cmdValid && cmdByte == b;
  endsequence
  a_write_silent: assert property (cmdValid && !cmdByte[0] |=> !readValid)
    else $error("write produced a read answer");
  a_rt_answer: assert property (s_take(8'h4D) |=> readValid)
    else $error("realtime read not answered");
  a_mask_answer: assert property (s_take(8'h6D) |=> readValid)
    else $error("mask read not answered");
  a_fail_flag: assert property (s_take(8'h55) |=> readValid && readData[5] == $past(clockSyncFail))
    else $error("clock fail bit wrong");
  a_scale_decode: assert property (fullLoopback[0] == (scaleCfg[0].scaleCode == 5'h10)
    && scaleCutoff[0] == (scaleCfg[0].scaleCode == 5'h00))
    else $error("scale decode wrong");
  a_oper_write: assert property (s_take(8'h60) ##0 chanEnable[0] |=> operCfg[0] == $past(cmdData))
    else $error("operating functions not written");
  a_oper_ignore: assert property (s_take(8'h60) ##0 !chanEnable[1] |=> $stable(operCfg[1]))
    else $error("disabled channel was written");
  a_irq_hold: assert property (!irq_n && !clrReq |=> !irq_n)
    else $error("interrupt released without clear");
  a_irq_release: assert property ($rose(irq_n) |-> $past(clrReq))
    else $error("interrupt rose without a clearing read");
endmodule // ccr_checker
bind ccr_channel_config_registers ccr_checker #(.NUM_CH(NUM_CH)) ccr_checker_i (.clk(clk), .rst(rst),
  .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdData(cmdData), .readData(readData), .readValid(readValid),
  .chanEnable(chanEnable), .clockSyncFail(clockSyncFail), .scaleCfg(scaleCfg), .fullLoopback(fullLoopback),
  .scaleCutoff(scaleCutoff), .operCfg(operCfg), .irq_n(irq_n));

// >>> ccr_host_model.sv
// host side of the deframed command port
// assumes the bench calls xfer, one command at a time
`timescale 1ns/1ps
module ccr_host_model (
  // clock
  input wire logic       clk,
  // command port
  output logic           cmdValid,
  output logic     [7:0] cmdByte,
  output logic     [7:0] cmdData,
  input wire logic       readValid,
  input wire logic [7:0] readData
);
  initial begin
    cmdValid = 1'b0;
    cmdByte = 8'h00;
    cmdData = 8'h00;
  end
  task automatic xfer(input logic [7:0] b, input logic [7:0] d, output logic v, output logic [7:0] r);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdByte <= b;
    cmdData <= (b == 8'h54) ? (d & 8'h1F) : d;
    @(posedge clk);
    cmdValid <= 1'b0;
    // idle lines flip so stale values never look valid
    cmdByte <= ~b;
    cmdData <= ~d;
    #1;
    v = readValid;
    r = readData;
  endtask
endmodule // ccr_host_model

// >>> ccr_channel_config_registers_bench.sv
// self-checking bench for the channel configuration register bank
// assumes the host model and checker files are compiled alongside
`timescale 1ns/1ps
module ccr_channel_config_registers_bench
  import ccr_pkg::*;
;
  logic clk, rst, cmdValid, readValid, chanEnableLoad, clockSyncFail, e1MultiplexEnable, irq_n, v;
  logic [7:0] cmdByte, cmdData, readData, realtimeBits, r;
  logic [3:0] chanEnableWr, chanEnable, channelActive, muxedLineBit, lineOutBit6, lineOutBit7, fullLoopback, scaleCutoff;
  logic [4:0] lineIoOut, lineIoOe;
  ccr_scale_type [3:0] scaleCfg;
  ccr_oper_type [3:0] operCfg;
  int failCount, checks, cycles;
  ccr_channel_config_registers ccr_channel_config_registers_i (.clk(clk), .rst(rst), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .cmdData(cmdData), .readData(readData), .readValid(readValid),
    .chanEnableWr(chanEnableWr), .chanEnableLoad(chanEnableLoad), .chanEnable(chanEnable),
    .channelActive(channelActive), .clockSyncFail(clockSyncFail), .e1MultiplexEnable(e1MultiplexEnable),
    .realtimeBits(realtimeBits), .lineIoIn(5'h00), .lineIoOut(lineIoOut), .lineIoOe(lineIoOe),
    .muxedLineBit(muxedLineBit), .lineOutBit6(lineOutBit6), .lineOutBit7(lineOutBit7), .scaleCfg(scaleCfg),
    .fullLoopback(fullLoopback), .scaleCutoff(scaleCutoff), .operCfg(operCfg), .irq_n(irq_n));
  ccr_host_model ccr_host_model_i (.clk(clk), .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdData(cmdData),
    .readValid(readValid), .readData(readData));
  // ----------------
  // helpers
  // ----------------
  task automatic finalReport;
    if (failCount == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic [7:0] d);
    ccr_host_model_i.xfer(b, d, v, r);
  endtask
  task automatic rd(input logic [7:0] b, input logic [7:0] exp);
    ccr_host_model_i.xfer(b, 8'h00, v, r);
    chk({7'h00, v}, 8'h01);
    chk(r, exp);
  endtask
  task automatic load(input logic [3:0] e);
    @(posedge clk);
    chanEnableLoad <= 1'b1;
    chanEnableWr <= e;
    @(posedge clk);
    chanEnableLoad <= 1'b0;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic tReset;
    rd(8'h51, 8'h00);
    rd(8'h61, 8'h00);
    rd(8'h6D, 8'hFF);
    rd(8'h55, 8'h60);
  endtask
  task automatic tScale;
    logic [7:0] tbl [4] = '{8'h90, 8'h60, 8'h1F, 8'h00};
    foreach (tbl[i]) begin
      wr(8'h50, tbl[i]);
      chk(scaleCfg[0], tbl[i]);
      chk({4'h0, fullLoopback}, (tbl[i][4:0] == 5'h10) ? 8'h0F : 8'h00);
      chk({4'h0, scaleCutoff}, (tbl[i][4:0] == 5'h00) ? 8'h0F : 8'h00);
    end
  endtask
  task automatic tLine;
    wr(8'h54, 8'h05);
    wr(8'h52, 8'hFF);
    chk({3'h0, lineIoOe}, 8'h05);
    chk({3'h0, lineIoOut & 5'h05}, 8'h05);
    chk({lineOutBit7, lineOutBit6}, 8'hFF);
    chk({4'h0, muxedLineBit}, 8'h0F);
    @(posedge clk);
    e1MultiplexEnable <= 1'b0;
    @(posedge clk);
    #1 chk({4'h0, muxedLineBit}, 8'h00);
    @(posedge clk);
    e1MultiplexEnable <= 1'b1;
    rd(8'h53, 8'hFF);
    wr(8'h52, 8'h00);
    chk({3'h0, lineIoOut & 5'h05}, 8'h00);
  endtask
  task automatic tEnable;
    load(4'h1);
    wr(8'h60, 8'hA5);
    chk(operCfg[0], 8'hA5);
    chk(operCfg[1], 8'h00);
    wr(8'h50, 8'h33);
    chk(scaleCfg[0], 8'h33);
    chk(scaleCfg[1], 8'h00);
    rd(8'h55, 8'h65);
    load(4'h2);
    rd(8'h55, 8'h25);
    rd(8'h51, 8'h00);
    load(4'h0);
    rd(8'h55, 8'h20);
    ccr_host_model_i.xfer(8'h61, 8'h00, v, r);
    chk({7'h00, v}, 8'h00);
    @(posedge clk);
    clockSyncFail <= 1'b0;
    rd(8'h55, 8'h00);
    rd(8'h6D, 8'hFF);
    @(posedge clk);
    clockSyncFail <= 1'b1;
    load(4'hF);
  endtask
  task automatic tIrq;
    wr(8'h6C, 8'hFE);
    @(posedge clk);
    realtimeBits <= 8'h02;
    repeat (3) @(posedge clk);
    #1 chk({7'h00, irq_n}, 8'h01);
    @(posedge clk);
    realtimeBits <= 8'h03;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq_n}, 8'h00);
    rd(8'h4D, 8'h03);
    chk({7'h00, irq_n}, 8'h00);
    rd(8'h4F, 8'h03);
    @(posedge clk);
    #1 chk({7'h00, irq_n}, 8'h01);
  endtask
  task automatic tRestart;
    wr(8'h60, 8'h5A);
    chk(operCfg[3], 8'h5A);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk({4'h0, chanEnable}, 8'h0F);
    chk({7'h00, irq_n}, 8'h01);
    rd(8'h61, 8'h00);
    rd(8'h6D, 8'hFF);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq_n}, 8'h01);
  endtask
  // ----------------
  // clock, watchdog, main
  // ----------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the whole sequence needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failCount++;
      finalReport();
    end
  end
  initial begin
    rst = 1'b1;
    chanEnableLoad = 1'b0;
    chanEnableWr = 4'h0;
    channelActive = 4'h5;
    clockSyncFail = 1'b1;
    e1MultiplexEnable = 1'b1;
    realtimeBits = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tReset();
    tScale();
    tLine();
    tEnable();
    tIrq();
    tRestart();
    finalReport();
  end
endmodule // ccr_channel_config_registers_bench
